/* File: hw/bdt_tx_stage.sv */
// transmit pin stage: pair fifo, word crossing, serialiser, data-strobe encoder
// Contract
// - sclk_out runs at half the serial data rate.
// - fast rate gives 49.152 MHz sclk, slow rate 24.576 MHz.
// - sclk_out is synchronous with link-side word transfers.
// - pair bits leave serially on tx_data_out, one per bit period.
// - encoded strobe is driven on tx_strobe_out.
// - tristate enable only for data, arbitration state 1 or bus reset.
// - tx_tristate_enable_n is active low.
// - polarity invert flips data, strobe and enable outputs.
// - open_collector_enable_n active low, enables both lines, also inverted.
// - two bits per word, latched, serialised, then data-strobe encoded.
module bdt_tx_stage
    import bdt_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [BDT_PAIR_W-1:0] tx_bits,
    input wire logic [BDT_MODE_W-1:0] tx_mode,
    input wire logic link_clk,
    input wire logic output_polarity_invert,
    output logic sclk_out,
    output logic tx_data_out,
    output logic tx_strobe_out,
    output logic tx_tristate_enable_n,
    output logic open_collector_enable_n
);
    // core side
    logic [BDT_WORD_W-1:0] fifo_in_w;
    logic [BDT_WORD_W-1:0] fifo_out_w;
    logic fifo_out_valid_w;
    logic fifo_out_ready_w;
    logic req_q;
    logic [BDT_WORD_W-1:0] word_q;
    logic ack_s;
    logic idle_w;

    // link side
    logic link_rst_n;
    logic req_s;
    logic ack_q;
    logic lvalid_q;
    logic [BDT_WORD_W-1:0] hold_q;
    logic phase_q;
    bdt_mode_t cur_mode_q;
    logic cur_lo_q;
    logic inv_s;
    logic inv_q;
    logic data_raw_q;
    logic strb_raw_q;
    logic en_raw_q;
    logic dmode_q;
    logic take_w;
    logic load_w;
    bdt_mode_t hold_mode_w;
    bdt_mode_t mode_d;
    logic bit_d;
    logic dmode_d;
    logic active_d;
    logic data_d;
    logic strb_d;
    logic link_off_w;

    assign fifo_in_w = {tx_mode, tx_bits};

    bdt_fifo #(
        .W(BDT_WORD_W),
        .DEPTH(BDT_FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rstn(rstn),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(fifo_in_w),
        .out_valid(fifo_out_valid_w),
        .out_ready(fifo_out_ready_w),
        .out_data(fifo_out_w)
    );

    bdt_sync #(.W(1)) u_sync_ack (
        .clk(core_clk),
        .d(ack_q),
        .q(ack_s)
    );

    // handshake idle when ack caught up
    assign idle_w = (req_q == ack_s);
    assign fifo_out_ready_w = idle_w;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            req_q <= 1'b0;
            word_q <= '0;
        end else if (idle_w && fifo_out_valid_w) begin
            req_q <= ~req_q;
            word_q <= fifo_out_w;
        end
    end

    // link domain reset and level crossings
    bdt_sync #(.W(1)) u_sync_rst (
        .clk(link_clk),
        .d(rstn),
        .q(link_rst_n)
    );

    bdt_sync #(.W(1)) u_sync_req (
        .clk(link_clk),
        .d(req_q),
        .q(req_s)
    );

    bdt_sync #(.W(1)) u_sync_inv (
        .clk(link_clk),
        .d(output_polarity_invert),
        .q(inv_s)
    );

    assign take_w = !lvalid_q && (req_s != ack_q);
    // words taken only at sclk phase
    assign load_w = !phase_q && lvalid_q;
    assign hold_mode_w = bdt_mode_t'(hold_q[BDT_WORD_W-1:BDT_PAIR_W]);

    assign mode_d = phase_q ? cur_mode_q : (load_w ? hold_mode_w : BDT_MODE_IDLE);
    assign bit_d = phase_q ? cur_lo_q : (load_w && hold_q[BDT_BIT_HI]);
    assign dmode_d = (mode_d == BDT_MODE_DATA);
    // enable only for data, arb1, reset
    assign active_d = (mode_d != BDT_MODE_IDLE);
    assign data_d = dmode_d ? bit_d : active_d;
    assign strb_d = dmode_d ? ((bit_d == data_raw_q) ? ~strb_raw_q : strb_raw_q) : active_d;
    // link checks off until both resets clear
    assign link_off_w = !rstn || !link_rst_n;

    // word holding register
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            ack_q <= 1'b0;
            lvalid_q <= 1'b0;
            hold_q <= '0;
        end else if (take_w) begin
            ack_q <= req_s;
            lvalid_q <= 1'b1;
            hold_q <= word_q;
        end else if (load_w) begin
            lvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            phase_q <= 1'b0;
            sclk_out <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            sclk_out <= ~phase_q;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            cur_mode_q <= BDT_MODE_IDLE;
            cur_lo_q <= 1'b0;
        end else if (!phase_q) begin
            cur_mode_q <= mode_d;
            cur_lo_q <= load_w && hold_q[BDT_BIT_LO];
        end
    end

    // raw encoder state
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            data_raw_q <= BDT_LINE_RST;
            strb_raw_q <= BDT_LINE_RST;
            en_raw_q <= 1'b0;
            dmode_q <= 1'b0;
            inv_q <= 1'b0;
        end else begin
            data_raw_q <= data_d;
            strb_raw_q <= strb_d;
            en_raw_q <= active_d;
            dmode_q <= dmode_d;
            inv_q <= inv_s;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            tx_data_out <= BDT_LINE_RST;
            tx_strobe_out <= BDT_LINE_RST;
            tx_tristate_enable_n <= BDT_EN_N_RST;
            open_collector_enable_n <= BDT_EN_N_RST;
        end else begin
            tx_data_out <= data_d ^ inv_s;
            tx_strobe_out <= strb_d ^ inv_s;
            tx_tristate_enable_n <= ~active_d ^ inv_s;
            open_collector_enable_n <= ~active_d ^ inv_s;
        end
    end

    // checks
    sequence s_sclk_rise;
        !sclk_out ##1 sclk_out;
    endsequence

    sequence s_data_pair;
        dmode_q ##1 dmode_q;
    endsequence

    sequence s_en_rise;
        !en_raw_q ##1 en_raw_q;
    endsequence

    sequence s_load_live;
        load_w && (hold_mode_w != BDT_MODE_IDLE);
    endsequence

    AST_SCLK_HALF: assert property (@(posedge link_clk) disable iff (link_off_w)
        s_sclk_rise |=> !sclk_out ##1 sclk_out)
        else $error("sclk not half of bit rate");

    AST_LOAD_SYNC: assert property (@(posedge link_clk) disable iff (link_off_w)
        load_w |=> sclk_out && phase_q)
        else $error("word load not aligned with sclk");

    AST_HI_BIT: assert property (@(posedge link_clk) disable iff (link_off_w)
        (load_w && hold_mode_w == BDT_MODE_DATA)
            |=> (data_raw_q == $past(hold_q[BDT_BIT_HI])))
        else $error("high bit not sent first");

    AST_SERIAL_LO: assert property (@(posedge link_clk) disable iff (link_off_w)
        (phase_q && cur_mode_q == BDT_MODE_DATA) |=> (data_raw_q == $past(cur_lo_q)))
        else $error("low bit not serialised");

    AST_DS_ONE_EDGE: assert property (@(posedge link_clk) disable iff (link_off_w)
        s_data_pair |-> ($changed(data_raw_q) != $changed(strb_raw_q)))
        else $error("data and strobe edges not exclusive");

    AST_STROBE_PIN: assert property (@(posedge link_clk) disable iff (link_off_w)
        ##1 (tx_strobe_out == (strb_raw_q ^ inv_q)))
        else $error("strobe pin mismatch");

    AST_EN_ARB1: assert property (@(posedge link_clk) disable iff (link_off_w)
        (en_raw_q && !dmode_q) |-> (data_raw_q && strb_raw_q))
        else $error("enable outside data without state 1");

    AST_IDLE_OFF: assert property (@(posedge link_clk) disable iff (link_off_w)
        (!phase_q && !load_w) |=> (!en_raw_q && !data_raw_q && !strb_raw_q))
        else $error("lines active without a word");

    AST_EN_LOW: assert property (@(posedge link_clk) disable iff (link_off_w)
        ##1 (tx_tristate_enable_n == (~en_raw_q ^ inv_q)))
        else $error("tristate enable polarity wrong");

    AST_EN_DATA_LOW: assert property (@(posedge link_clk) disable iff (link_off_w)
        s_load_live |=> (tx_tristate_enable_n == $past(inv_s)))
        else $error("enable not asserted for loaded word");

    AST_INVERT: assert property (@(posedge link_clk) disable iff (link_off_w)
        ##1 (tx_data_out == (data_raw_q ^ inv_q)))
        else $error("data pin polarity wrong");

    AST_ARB1_PINS: assert property (@(posedge link_clk) disable iff (link_off_w)
        (load_w && hold_mode_w == BDT_MODE_ARB1)
            |=> (tx_data_out != $past(inv_s)) && (tx_strobe_out != $past(inv_s)))
        else $error("arbitration pins ignore polarity");

    AST_OC_EN: assert property (@(posedge link_clk) disable iff (link_off_w)
        open_collector_enable_n == tx_tristate_enable_n)
        else $error("open collector enable mismatch");

    AST_EN_PAIR: assert property (@(posedge link_clk) disable iff (link_off_w)
        s_en_rise |-> sclk_out ##1 en_raw_q)
        else $error("enable not aligned to a bit pair");

    AST_ACK_TAKE: assert property (@(posedge link_clk) disable iff (link_off_w)
        take_w |=> lvalid_q && (ack_q == $past(req_s)))
        else $error("crossing word not acknowledged");

    AST_WORD_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        (req_q != ack_s) |=> $stable(word_q))
        else $error("crossing word changed in flight");

    AST_REQ_IDLE: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(req_q) |-> $past(idle_w && fifo_out_valid_w))
        else $error("request toggled while busy");
endmodule : bdt_tx_stage

/* File: hw/bdt_pkg.sv */
// shared constants and types for the backplane transmit pin stage
package bdt_pkg;
    localparam int BDT_SCLK_DIV = 2;
    localparam int BDT_RATE_FAST_KBPS = 98304;
    localparam int BDT_RATE_SLOW_KBPS = 49152;
    localparam int BDT_SCLK_FAST_KHZ = BDT_RATE_FAST_KBPS / BDT_SCLK_DIV;
    localparam int BDT_SCLK_SLOW_KHZ = BDT_RATE_SLOW_KBPS / BDT_SCLK_DIV;
    localparam int BDT_CORE_CLK_KHZ = 50000;
    localparam int BDT_FIFO_DEPTH = 16;
    localparam int BDT_PAIR_W = 2;
    localparam int BDT_MODE_W = 2;
    localparam int BDT_WORD_W = BDT_PAIR_W + BDT_MODE_W;
    localparam int BDT_SYNC_STAGES = 2;
    localparam int BDT_BIT_HI = 1;
    localparam int BDT_BIT_LO = 0;
    localparam logic BDT_LINE_RST = 1'h0;
    localparam logic BDT_EN_N_RST = 1'h1;
    typedef enum logic [1:0] {
        BDT_MODE_IDLE,
        BDT_MODE_DATA,
        BDT_MODE_ARB1,
        BDT_MODE_BRST
    } bdt_mode_t;
endpackage : bdt_pkg

/* File: hw/bdt_sync.sv */
// two-flop level synchroniser
module bdt_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule : bdt_sync

/* File: hw/bdt_fifo.sv */
// synchronous fifo with valid/ready on both sides
module bdt_fifo #(
    parameter int W = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic push_w;
    logic pop_w;

    assign out_valid = (count_q != '0);
    assign push_w = in_valid && in_ready;
    assign pop_w = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];
    assign count_d = count_q + (AW + 1)'(push_w) - (AW + 1)'(pop_w);

    always_ff @(posedge clk) begin
        if (push_w) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(push_w);
            rd_ptr_q <= rd_ptr_q + AW'(pop_w);
            count_q <= count_d;
            in_ready <= (count_d != FULL_CNT);
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rstn)
        (count_q == FULL_CNT) |-> !in_ready)
        else $error("fifo full but ready high");
endmodule : bdt_fifo

/* File: dv/bdt_xcvr_model.sv */
// far-side transceiver model: samples the pins once per bit period
module bdt_xcvr_model (
    input wire logic link_clk,
    input wire logic inv,
    input wire logic sclk_out,
    input wire logic tx_data_out,
    input wire logic tx_strobe_out,
    input wire logic tx_tristate_enable_n,
    input wire logic open_collector_enable_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // entries are {sclk, data, strobe} with polarity undone
    logic [2:0] pq[$];
    int en_bad = 0;
    int sclk_bad = 0;
    logic run = 1'h0;
    logic sclk_prev = 1'h0;
    always @(negedge link_clk) begin
        if (open_collector_enable_n !== tx_tristate_enable_n) en_bad++;
        if (run && sclk_out === sclk_prev) sclk_bad++;
        if (sclk_out === 1'h1) run = 1'h1;
        sclk_prev = sclk_out;
        if ((tx_tristate_enable_n ^ inv) === 1'h0) begin
            pq.push_back({sclk_out, tx_data_out ^ inv, tx_strobe_out ^ inv});
        end
    end
endmodule : bdt_xcvr_model

/* File: dv/test_backplane_ds_tx_pin_stage.sv */
// self-checking bench for the transmit pin stage
module test_backplane_ds_tx_pin_stage;
    timeunit 1ns;
    timeprecision 100ps;
    import bdt_pkg::*;
    logic core_clk = 1'h0;
    logic link_clk = 1'h0;
    logic rstn = 1'h0;
    logic tx_valid = 1'h0;
    logic [1:0] tx_bits = 2'h0;
    logic [1:0] tx_mode = 2'h0;
    logic inv = 1'h0;
    logic full_seen = 1'h0;
    logic tx_ready, sclk_out, tx_data_out, tx_strobe_out, en_n, oc_n;
    int num_errors = 0;
    int n_compared = 0;
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    bdt_tx_stage bdt_tx_stage_inst (.core_clk(core_clk), .rstn(rstn), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_bits(tx_bits), .tx_mode(tx_mode), .link_clk(link_clk),
        .output_polarity_invert(inv), .sclk_out(sclk_out), .tx_data_out(tx_data_out),
        .tx_strobe_out(tx_strobe_out), .tx_tristate_enable_n(en_n),
        .open_collector_enable_n(oc_n));
    bdt_xcvr_model bdt_xcvr_model_inst (.link_clk(link_clk), .inv(inv), .sclk_out(sclk_out),
        .tx_data_out(tx_data_out), .tx_strobe_out(tx_strobe_out),
        .tx_tristate_enable_n(en_n), .open_collector_enable_n(oc_n));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // offers one word, returns at the negedge after it was taken, valid left high
    task automatic send(input logic [1:0] b, input logic [1:0] m);
        int k;
        k = 0;
        tx_valid = 1'h1;
        tx_bits = b;
        tx_mode = m;
        while (tx_ready !== 1'h1 && k < 500) begin
            full_seen = 1'h1;
            @(negedge core_clk);
            k++;
        end
        check("ready_wait", 8'(k >= 500), 8'h00);
        @(negedge core_clk);
    endtask : send
    task automatic settle(input int n);
        int k;
        k = 0;
        while (bdt_xcvr_model_inst.pq.size() < n && k < 3000) begin
            @(negedge core_clk);
            k++;
        end
        check("settle_wait", 8'(k >= 3000), 8'h00);
        repeat (12) @(negedge core_clk);
    endtask : settle
    task automatic t_data(input logic iv);
        logic s1, s0;
        inv = iv;
        repeat (10) @(negedge core_clk);
        bdt_xcvr_model_inst.pq.delete();
        for (int v = 0; v < 4; v++) begin
            send(v[1:0], BDT_MODE_DATA);
            tx_valid = 1'h0;
            settle(2);
            s1 = ~v[1];
            s0 = (v[1] == v[0]) ? ~s1 : s1;
            check("pairs", 8'(bdt_xcvr_model_inst.pq.size()), 8'h02);
            check("first", bdt_xcvr_model_inst.pq[0], {1'h1, v[1], s1});
            check("second", bdt_xcvr_model_inst.pq[1], {1'h0, v[0], s0});
            bdt_xcvr_model_inst.pq.delete();
        end
        $display("t_data invert %0d done", iv);
    endtask : t_data
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            if (m != 1) begin
                send(m[1:0], m[1:0]);
                tx_valid = 1'h0;
                if (m == 0) begin
                    repeat (100) @(negedge core_clk);
                end else begin
                    settle(2);
                end
                check("mode_pairs", 8'(bdt_xcvr_model_inst.pq.size()), m ? 8'h02 : 8'h00);
                if (m > 1) begin
                    check("mode_lines", bdt_xcvr_model_inst.pq[0][1:0], 8'h03);
                    check("mode_lines", bdt_xcvr_model_inst.pq[1][1:0], 8'h03);
                end
                bdt_xcvr_model_inst.pq.delete();
            end
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_fifo();
        full_seen = 1'h0;
        bdt_xcvr_model_inst.pq.delete();
        for (int i = 0; i < 32; i++) begin
            send(i[1:0], BDT_MODE_DATA);
        end
        tx_valid = 1'h0;
        settle(64);
        check("refused", full_seen, 8'h01);
        check("count", 8'(bdt_xcvr_model_inst.pq.size()), 8'h40);
        for (int i = 0; i < 32; i++) begin
            check("bit1", bdt_xcvr_model_inst.pq[2 * i][1], i[1]);
            check("bit0", bdt_xcvr_model_inst.pq[2 * i + 1][1], i[0]);
        end
        $display("t_fifo done");
    endtask : t_fifo
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        check("ready_rst", tx_ready, 8'h00);
        check("en_rst", {en_n, oc_n}, 8'h03);
        repeat (6) @(negedge core_clk);
        rstn = 1'h1;
        repeat (10) @(negedge core_clk);
        t_data(1'h0);
        t_data(1'h1);
        inv = 1'h0;
        repeat (10) @(negedge core_clk);
        bdt_xcvr_model_inst.pq.delete();
        t_modes();
        t_fifo();
        check("sclk_bad", 8'(bdt_xcvr_model_inst.sclk_bad), 8'h00);
        check("en_bad", 8'(bdt_xcvr_model_inst.en_bad), 8'h00);
        end_sim();
    end
endmodule : test_backplane_ds_tx_pin_stage
